//--- hw/csrb_map.svh
// register indices, field positions and reset values of the core system register bank
// assumes inclusion by bare name; the byte address of a register is four times its index
`ifndef CSRB_MAP_SVH
`define CSRB_MAP_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define CSRB_IDX_FLAGS     4'h0
`define CSRB_IDX_SP        4'h2
`define CSRB_IDX_CLKMD     4'h3
`define CSRB_IDX_INTEN     4'h4
`define CSRB_IDX_INTRQ     4'h5
`define CSRB_IDX_INTCLR    4'h6

// ****************************************
// field positions
// ****************************************
`define CSRB_FLG_OV        2'd3
`define CSRB_FLG_AC        2'd2
`define CSRB_FLG_C         2'd1
`define CSRB_FLG_Z         2'd0
`define CSRB_FLG_HIGH_ONES 4'hf
`define CSRB_CMD_SEL_HI    3'd7
`define CSRB_CMD_SEL_LO    3'd5
`define CSRB_CMD_FAST_EN   3'd4
`define CSRB_CMD_TYPE      3'd3
`define CSRB_CMD_SLOW_EN   3'd2
`define CSRB_CMD_WDT_EN    3'd1
`define CSRB_CMD_PIN_FN    3'd0

// ****************************************
// reset values
// ****************************************
`define CSRB_RST_FLAGS     4'h0
`define CSRB_RST_SP        8'h00
`define CSRB_RST_CLKMD     8'he6
`define CSRB_RST_INTEN     8'h00
`define CSRB_RST_INTRQ     8'h00

`endif

//--- hw/csrb_pkg.sv
// types shared by the core system register bank and its surroundings
// assumes nothing beyond a SystemVerilog compiler
package csrb_pkg;

  // one alu result: per-flag write enables and the new values
  typedef struct packed {
    logic ov_we;
    logic ac_we;
    logic c_we;
    logic z_we;
    logic ov;
    logic ac;
    logic c;
    logic z;
  } csrb_alu_upd_t;

  // decoded system clock choice
  typedef struct packed {
    logic       src_fast;
    logic [6:0] divide;
    logic       reserved_code;
  } csrb_clk_cfg_t;

  typedef enum logic [1:0] {
    CSRB_RESP_OKAY   = 2'b00,
    CSRB_RESP_SLVERR = 2'b10
  } csrb_resp_t;

endpackage

//--- hw/csrb_top.sv
// core system register bank: alu flags, stack pointer, clock mode, interrupt enable/request
// assumes one clock aclk, synchronous active-low aresetn, an AXI4-Lite master and
// alu/core/peripheral strobes generated on aclk
`timescale 1ns/1ps
`include "csrb_map.svh"

module csrb_top #(
  parameter int ADDR_W = 6
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // core side
  input  wire csrb_pkg::csrb_alu_upd_t alu_upd,
  input  wire logic                    sp_core_we,
  input  wire logic [7:0]              sp_core_data,
  input  wire logic [7:0]              irq_event,
  output logic [7:0]                   alu_flags,
  output logic [7:0]                   stack_pointer,
  output csrb_pkg::csrb_clk_cfg_t      clk_cfg,
  output logic                         fast_internal_osc_en,
  output logic                         slow_internal_osc_en,
  output logic                         watchdog_en,
  output logic                         external_reset_pin_sel,
  output logic                         irq
);
  import csrb_pkg::*;

  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W must be at least 6 to reach all registers");
  end

  // ****************************************
  // reset images
  // ****************************************
  // bit-wide views of the packed reset words, so each per-bit flop takes one bit on purpose
  localparam logic [3:0] FLAGS_RST = `CSRB_RST_FLAGS;
  localparam logic [7:0] INTRQ_RST = `CSRB_RST_INTRQ;
  // the clock-mode outputs leave reset showing what the register itself resets to
  localparam logic [7:0] CLKMD_RST = `CSRB_RST_CLKMD;
  // ce low holds every flop below, bus handshakes included, so a frozen bank never answers

  // ****************************************
  // register state
  // ****************************************
  logic [3:0] flags_low;
  logic [7:0] sp;
  logic [7:0] clock_mode_control;
  logic [7:0] interrupt_enable_mask;
  logic [7:0] interrupt_request_flags;

  // ****************************************
  // write channel
  // ****************************************
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_full;
  logic [7:0]        w_data;
  logic              w_lane0;
  logic              w_full;
  logic              aw_hs;
  logic              w_hs;
  logic              do_write;
  logic              next_aw_full;
  logic              next_w_full;
  logic [3:0]        wr_idx;
  logic              wr_hit;

  assign aw_hs        = s_axi_awvalid & s_axi_awready;
  assign w_hs         = s_axi_wvalid & s_axi_wready;
  // both halves are latched first so address and data may arrive in any order
  assign do_write     = aw_full & w_full & ~s_axi_bvalid;
  assign next_aw_full = (aw_full | aw_hs) & ~do_write;
  assign next_w_full  = (w_full | w_hs) & ~do_write;
  assign wr_idx       = aw_addr[5:2];

  // any address bit above the map turns the write into an error with no state change;
  // a shift is used so that the default width of 6 leaves nothing above to select
  always_comb begin
    wr_hit = 1'b0;
    if ((aw_addr >> 6) == '0) begin
      unique case (wr_idx)
        `CSRB_IDX_FLAGS, `CSRB_IDX_SP, `CSRB_IDX_CLKMD, `CSRB_IDX_INTEN,
        `CSRB_IDX_INTRQ, `CSRB_IDX_INTCLR: wr_hit = 1'b1;
        default:                           wr_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (ce) begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready  <= ~next_w_full;
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  // the response waits for bready; no further write is performed until it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CSRB_RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? CSRB_RESP_OKAY : CSRB_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // only lane 0 carries a register byte; a write without it is answered and dropped
  logic sw_wr;
  assign sw_wr = do_write & wr_hit & w_lane0;

  // ****************************************
  // alu status flags
  // ****************************************
  logic [3:0] hw_we;
  logic [3:0] hw_val;
  assign hw_we  = {alu_upd.ov_we, alu_upd.ac_we, alu_upd.c_we, alu_upd.z_we};
  assign hw_val = {alu_upd.ov, alu_upd.ac, alu_upd.c, alu_upd.z};

  // the alu retires flags in the same cycle software may write them; the alu wins
  for (genvar b = 0; b < 4; b++) begin : g_flag
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flags_low[b] <= FLAGS_RST[b];
      end else if (ce) begin
        if (hw_we[b]) begin
          flags_low[b] <= hw_val[b];
        end else if (sw_wr && wr_idx == `CSRB_IDX_FLAGS) begin
          flags_low[b] <= w_data[b];
        end
      end
    end
  end

  // ****************************************
  // stack pointer
  // ****************************************
  // core push/pop moves the pointer; a software write in the same cycle loses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp <= `CSRB_RST_SP;
    end else if (ce) begin
      if (sp_core_we) begin
        sp <= sp_core_data;
      end else if (sw_wr && wr_idx == `CSRB_IDX_SP) begin
        sp <= w_data;
      end
    end
  end

  // ****************************************
  // clock mode and interrupt enables
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_mode_control <= `CSRB_RST_CLKMD;
    end else if (ce && sw_wr && wr_idx == `CSRB_IDX_CLKMD) begin
      clock_mode_control <= w_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_enable_mask <= `CSRB_RST_INTEN;
    end else if (ce && sw_wr && wr_idx == `CSRB_IDX_INTEN) begin
      interrupt_enable_mask <= w_data;
    end
  end

  // ****************************************
  // interrupt requests
  // ****************************************
  // bit order, msb first: counter3/pulse_gen_2, counter2, pulse_gen_0, comparator/pulse_gen_1,
  // converter, sixteen_bit_counter overflow, port_b_line0/port_a_line4,
  // port_a_line0/port_b_line5
  logic [7:0] sw_clear;
  always_comb begin
    sw_clear = 8'h00;
    if (sw_wr && wr_idx == `CSRB_IDX_INTRQ) begin
      sw_clear = ~w_data;
    end else if (sw_wr && wr_idx == `CSRB_IDX_INTCLR) begin
      sw_clear = w_data;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_req
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        interrupt_request_flags[i] <= INTRQ_RST[i];
      end else if (ce) begin
        if (irq_event[i]) begin
          interrupt_request_flags[i] <= 1'b1;
        end else if (sw_clear[i]) begin
          interrupt_request_flags[i] <= 1'b0;
        end
      end
    end
  end

  // irq trails the request bits by one cycle; an event beside a clear keeps it high,
  // since the set wins at the request bit itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(interrupt_request_flags & interrupt_enable_mask);
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic       ar_hs;
  logic       next_rvalid;
  logic [3:0] rd_idx;
  logic [7:0] rd_byte;
  logic       rd_hit;

  assign ar_hs       = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  // the index is decoded straight from the bus, so the data is latched at the taking edge
  // and a register that changes later does not alter a read already answered
  assign rd_idx      = s_axi_araddr[5:2];

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b0;
    if ((s_axi_araddr >> 6) == '0) begin
      rd_hit = 1'b1;
      unique case (rd_idx)
        `CSRB_IDX_FLAGS:  rd_byte = {`CSRB_FLG_HIGH_ONES, flags_low};
        `CSRB_IDX_SP:     rd_byte = sp;
        `CSRB_IDX_CLKMD:  rd_byte = clock_mode_control;
        `CSRB_IDX_INTEN:  rd_byte = interrupt_enable_mask;
        `CSRB_IDX_INTRQ:  rd_byte = interrupt_request_flags;
        `CSRB_IDX_INTCLR: rd_byte = 8'h00;
        default:          rd_hit  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CSRB_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? CSRB_RESP_OKAY : CSRB_RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // clock mode decode
  // ****************************************
  csrb_clk_cfg_t next_clk_cfg;
  logic [2:0]    sel;
  assign sel = clock_mode_control[`CSRB_CMD_SEL_HI:`CSRB_CMD_SEL_LO];

  // a reserved code keeps the last legal clock so the core never loses its clock
  always_comb begin
    next_clk_cfg               = clk_cfg;
    next_clk_cfg.reserved_code = 1'b0;
    if (!clock_mode_control[`CSRB_CMD_TYPE]) begin
      unique case (sel)
        3'h0:    next_clk_cfg = '{src_fast: 1'b1, divide: 7'h04, reserved_code: 1'b0};
        3'h1:    next_clk_cfg = '{src_fast: 1'b1, divide: 7'h02, reserved_code: 1'b0};
        3'h6:    next_clk_cfg = '{src_fast: 1'b0, divide: 7'h04, reserved_code: 1'b0};
        3'h7:    next_clk_cfg = '{src_fast: 1'b0, divide: 7'h01, reserved_code: 1'b0};
        default: next_clk_cfg.reserved_code = 1'b1;
      endcase
    end else begin
      unique case (sel)
        3'h0:    next_clk_cfg = '{src_fast: 1'b1, divide: 7'h10, reserved_code: 1'b0};
        3'h1:    next_clk_cfg = '{src_fast: 1'b1, divide: 7'h08, reserved_code: 1'b0};
        3'h2:    next_clk_cfg = '{src_fast: 1'b0, divide: 7'h10, reserved_code: 1'b0};
        3'h3:    next_clk_cfg = '{src_fast: 1'b1, divide: 7'h20, reserved_code: 1'b0};
        3'h4:    next_clk_cfg = '{src_fast: 1'b1, divide: 7'h40, reserved_code: 1'b0};
        default: next_clk_cfg.reserved_code = 1'b1;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_cfg                <= '{src_fast: 1'b0, divide: 7'h01, reserved_code: 1'b0};
      fast_internal_osc_en   <= CLKMD_RST[`CSRB_CMD_FAST_EN];
      slow_internal_osc_en   <= CLKMD_RST[`CSRB_CMD_SLOW_EN];
      watchdog_en            <= CLKMD_RST[`CSRB_CMD_WDT_EN] & CLKMD_RST[`CSRB_CMD_SLOW_EN];
      external_reset_pin_sel <= CLKMD_RST[`CSRB_CMD_PIN_FN];
      alu_flags              <= {`CSRB_FLG_HIGH_ONES, `CSRB_RST_FLAGS};
      stack_pointer          <= `CSRB_RST_SP;
    end else if (ce) begin
      clk_cfg                <= next_clk_cfg;
      fast_internal_osc_en   <= clock_mode_control[`CSRB_CMD_FAST_EN];
      slow_internal_osc_en   <= clock_mode_control[`CSRB_CMD_SLOW_EN];
      // the watchdog counts on the slow oscillator, so it stops with it
      watchdog_en            <= clock_mode_control[`CSRB_CMD_WDT_EN] &
                                clock_mode_control[`CSRB_CMD_SLOW_EN];
      external_reset_pin_sel <= clock_mode_control[`CSRB_CMD_PIN_FN];
      alu_flags              <= {`CSRB_FLG_HIGH_ONES, flags_low};
      stack_pointer          <= sp;
    end
  end

endmodule

//--- tb/csrb_assertions.sv
// port-level checker for csrb_top
// assumes the single aclk domain; bound to every csrb_top instance
`timescale 1ns/1ps
module csrb_assertions (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    ce,
  input wire csrb_pkg::csrb_alu_upd_t alu_upd,
  input wire logic                    sp_core_we,
  input wire logic [7:0]              sp_core_data,
  input wire logic [7:0]              alu_flags,
  input wire logic [7:0]              stack_pointer,
  input wire csrb_pkg::csrb_clk_cfg_t clk_cfg,
  input wire logic                    fast_internal_osc_en,
  input wire logic                    slow_internal_osc_en,
  input wire logic                    watchdog_en,
  input wire logic                    external_reset_pin_sel,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic [31:0]             s_axi_rdata
);
  import csrb_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  // ****
  // properties
  // ****
  // a lone strobe; back-to-back strobes would blur which value must show
  sequence one_upd(we);
    we ##1 !we;
  endsequence
  chk_high_ones: assert property (alu_flags[7:4] == 4'hf)
    else $error("flag high nibble not ones");
  chk_ov_follows: assert property (one_upd(alu_upd.ov_we) |-> ##1
    alu_flags[3] == $past(alu_upd.ov, 2)) else $error("overflow flag wrong");
  chk_ac_follows: assert property (one_upd(alu_upd.ac_we) |-> ##1
    alu_flags[2] == $past(alu_upd.ac, 2)) else $error("nibble flag wrong");
  chk_c_follows: assert property (one_upd(alu_upd.c_we) |-> ##1
    alu_flags[1] == $past(alu_upd.c, 2)) else $error("carry flag wrong");
  chk_z_follows: assert property (one_upd(alu_upd.z_we) |-> ##1
    alu_flags[0] == $past(alu_upd.z, 2)) else $error("zero flag wrong");
  chk_sp_load: assert property (one_upd(sp_core_we) |-> ##1
    stack_pointer == $past(sp_core_data, 2)) else $error("stack pointer load lost");
  chk_wdt_needs_slow: assert property (watchdog_en |-> slow_internal_osc_en)
    else $error("watchdog on without slow oscillator");
  chk_reset_clock: assert property ($rose(aresetn) |-> clk_cfg == 9'h002
    && slow_internal_osc_en && watchdog_en && !fast_internal_osc_en && !external_reset_pin_sel)
    else $error("clock mode outputs not at reset values");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule

bind csrb_top csrb_assertions csrb_assertions_inst (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .alu_upd(alu_upd), .sp_core_we(sp_core_we),
  .sp_core_data(sp_core_data), .alu_flags(alu_flags), .stack_pointer(stack_pointer),
  .clk_cfg(clk_cfg), .fast_internal_osc_en(fast_internal_osc_en),
  .slow_internal_osc_en(slow_internal_osc_en), .watchdog_en(watchdog_en),
  .external_reset_pin_sel(external_reset_pin_sel), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata)
);

//--- tb/core_system_register_bank_tb.sv
// self-checking bench for csrb_top against a register model
// assumes csrb_pkg, csrb_map.svh and csrb_assertions are compiled first
`timescale 1ns/1ps
module core_system_register_bank_tb;
  import csrb_pkg::*;
  logic          aclk, aresetn, ce, sp_core_we, irq;
  logic [5:0]    s_axi_awaddr, s_axi_araddr;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic          s_axi_rvalid, s_axi_rready;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]    s_axi_wstrb, m_flags;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  csrb_alu_upd_t alu_upd;
  csrb_clk_cfg_t clk_cfg;
  logic [7:0]    sp_core_data, irq_event, alu_flags, stack_pointer;
  logic          fast_internal_osc_en, slow_internal_osc_en, watchdog_en;
  logic          external_reset_pin_sel, m_src, m_res;
  logic [7:0]    m_sp, m_clk, m_en, m_rq;
  logic [6:0]    m_div;
  logic [15:0]   lf;
  int            num_errors, tests_run;
  int            cycles = 0;

  csrb_top csrb_top_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .alu_upd(alu_upd),
    .sp_core_we(sp_core_we), .sp_core_data(sp_core_data), .irq_event(irq_event),
    .alu_flags(alu_flags), .stack_pointer(stack_pointer), .clk_cfg(clk_cfg),
    .fast_internal_osc_en(fast_internal_osc_en), .slow_internal_osc_en(slow_internal_osc_en),
    .watchdog_en(watchdog_en), .external_reset_pin_sel(external_reset_pin_sel), .irq(irq));

  // ****
  // helpers
  // ****
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  function automatic logic mapped(input logic [3:0] i);
    return i == 4'h0 || (i >= 4'h2 && i <= 4'h6);
  endfunction
  function automatic logic [7:0] mdl(input logic [3:0] i);
    case (i)
      4'h0: return {4'hf, m_flags};
      4'h2: return m_sp;
      4'h3: return m_clk;
      4'h4: return m_en;
      4'h5: return m_rq;
      default: return 8'h00;
    endcase
  endfunction
  task automatic clk_decode();
    m_res = 1'b0;
    case ({m_clk[3], m_clk[7:5]})
      4'h0: {m_src, m_div} = {1'b1, 7'd4};
      4'h1: {m_src, m_div} = {1'b1, 7'd2};
      4'h6: {m_src, m_div} = {1'b0, 7'd4};
      4'h7: {m_src, m_div} = {1'b0, 7'd1};
      4'h8: {m_src, m_div} = {1'b1, 7'd16};
      4'h9: {m_src, m_div} = {1'b1, 7'd8};
      4'ha: {m_src, m_div} = {1'b0, 7'd16};
      4'hb: {m_src, m_div} = {1'b1, 7'd32};
      4'hc: {m_src, m_div} = {1'b1, 7'd64};
      default: m_res = 1'b1;
    endcase
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [3:0] i);
    chk({30'h0, got}, {30'h0, mapped(i) ? CSRB_RESP_OKAY : CSRB_RESP_SLVERR});
  endtask
  task automatic chk_outs();
    repeat (2) @(posedge aclk);
    chk({23'h0, clk_cfg}, {23'h0, m_src, m_div, m_res});
    chk({28'h0, fast_internal_osc_en, slow_internal_osc_en, watchdog_en, external_reset_pin_sel},
        {28'h0, m_clk[4], m_clk[2], m_clk[1] & m_clk[2], m_clk[0]});
    chk({24'h0, alu_flags}, {24'h0, 4'hf, m_flags});
    chk({24'h0, stack_pointer}, {24'h0, m_sp});
    chk({31'h0, irq}, {31'h0, |(m_rq & m_en)});
  endtask
  // upper write lanes carry noise: only byte 0 may matter
  task automatic wr_m(input logic [3:0] i, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {rnd(), rnd(), rnd(), v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, i);
    // a write without lane 0 is answered but must leave every register alone
    if (s_axi_wstrb[0]) case (i)
      4'h0: m_flags = v[3:0];
      4'h2: m_sp = v;
      4'h3: begin
        m_clk = v;
        clk_decode();
      end
      4'h4: m_en = v;
      4'h5: m_rq = (m_rq & v) | irq_event;
      4'h6: m_rq = (m_rq & ~v) | irq_event;
      default: ;
    endcase
  endtask
  task automatic rd_chk(input logic [3:0] i);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, mdl(i)});
    chk_resp(s_axi_rresp, i);
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****
  // stimulus
  // ****
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] v;
    logic [7:0] r;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, alu_upd, sp_core_we, sp_core_data} = '0;
    {irq_event, num_errors, tests_run} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    lf = 16'hb0bc;
    {m_flags, m_sp, m_clk, m_en, m_rq} = {4'h0, 8'h00, 8'he6, 8'h00, 8'h00};
    clk_decode();
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(i[3:0]);
    chk_outs();
    for (int k = 0; k < 4; k++) begin
      wr_m(4'h0, rnd());
      rd_chk(4'h0);
    end
    for (int k = 0; k < 16; k++) begin
      v = rnd();
      @(posedge aclk);
      alu_upd <= v;
      @(posedge aclk);
      alu_upd <= 8'h00;
      for (int b = 0; b < 4; b++) if (v[4 + b]) m_flags[b] = v[b];
      rd_chk(4'h0);
      chk_outs();
    end
    s_axi_wstrb <= 4'he;
    wr_m(4'h0, {4'h0, ~m_flags});
    rd_chk(4'h0);
    s_axi_wstrb <= 4'hf;
    for (int k = 0; k < 3; k++) begin
      wr_m(4'h2, rnd() & 8'hfe);
      rd_chk(4'h2);
      v = rnd();
      @(posedge aclk);
      sp_core_data <= v;
      sp_core_we <= 1'b1;
      @(posedge aclk);
      sp_core_we <= 1'b0;
      m_sp = v;
      chk_outs();
    end
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      wr_m(4'h3, {k[2:0], r[4], k[3], r[2:0]});
      rd_chk(4'h3);
      chk_outs();
    end
    for (int k = 0; k < 6; k++) begin
      wr_m(4'h4, (k == 0) ? 8'h00 : rnd());
      v = rnd();
      @(posedge aclk);
      irq_event <= v;
      @(posedge aclk);
      irq_event <= 8'h00;
      m_rq = m_rq | v;
      chk_outs();
      rd_chk(4'h5);
      wr_m(4'h5, 8'hff);
      wr_m(4'h5, rnd());
      rd_chk(4'h5);
      wr_m(4'h6, rnd());
      rd_chk(4'h5);
      rd_chk(4'h4);
    end
    // a source held high across a clear must survive it
    @(posedge aclk);
    irq_event <= 8'h81;
    wr_m(4'h5, 8'h00);
    wr_m(4'h6, 8'hff);
    rd_chk(4'h5);
    @(posedge aclk);
    irq_event <= 8'h00;
    wr_m(4'h6, 8'hff);
    wr_m(4'h7, rnd());
    for (int i = 0; i < 8; i++) rd_chk(i[3:0]);
    chk_outs();
    // a low clock enable must freeze every register against every strobe
    @(posedge aclk);
    ce <= 1'b0;
    irq_event <= 8'hff;
    alu_upd <= 8'hff;
    sp_core_we <= 1'b1;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    {irq_event, alu_upd, sp_core_we} <= '0;
    chk_outs();
    for (int i = 0; i < 6; i++) rd_chk(i[3:0]);
    print_verdict();
  end
endmodule
